/* design/ltsr_pkg.sv */
// Purpose: Shared constants and carriers for the link training snoop registers.
// Assumes: Byte-wide register file reached by a local byte-address port.
// Notes:   Offsets are byte addresses on the local register port.
`default_nettype none
package ltsr_pkg;
  localparam logic [7:0] OFS_CLOCK_RATIO  = 8'h20;
  localparam logic [7:0] OFS_SINK_CONFIG  = 8'h31;
  localparam logic [7:0] OFS_SOURCE_TEST  = 8'h35;
  localparam logic [7:0] OFS_LANE01_REQ   = 8'h41;
  localparam logic [7:0] OFS_LANE23_REQ   = 8'h42;
  localparam logic [7:0] OFS_EQ_CONTROL2  = 8'h1E;
  localparam logic [7:0] RST_BYTE         = 8'h00;
  localparam logic [7:0] MASK_CLOCK_RATIO = 8'h02;
  localparam logic [7:0] MASK_SOURCE_TEST = 8'h2E;
  localparam logic [7:0] MASK_EQ_CONTROL2 = 8'hCF;
  localparam int         POS_RATIO        = 1;
  localparam int         POS_TIMEOUT_INH  = 5;
  localparam int         POS_FFE_DISABLE  = 3;
  localparam int         POS_DEEMPH_ONLY  = 2;
  localparam int         POS_TEST_A       = 1;
  localparam int         POS_POLARITY     = 3;
  localparam logic [3:0] REQ_FFE_ADVANCE  = 4'hE;
  localparam logic [3:0] REQ_FFE_CLEAR    = 4'hF;
  localparam logic [3:0] EQ_MAX           = 4'hF;
  localparam logic [3:0] RATE_MAX_CODE    = 4'h6;
  localparam logic [3:0] RATE_THREE_LANE  = 4'h2;

  typedef enum logic [1:0] {
    LTSR_EQM_FIXED    = 2'b00,
    LTSR_EQM_FULL     = 2'b01,
    LTSR_EQM_OTHER    = 2'b10,
    LTSR_EQM_RESERVED = 2'b11
  } ltsr_eq_mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } ltsr_access_t;

  typedef struct packed {
    logic        ffe_disable;
    logic        deemph_only;
    logic        test_a;
    logic        timeout_inhibit;
  } ltsr_test_t;
endpackage : ltsr_pkg
`default_nettype wire

/* design/ltsr_regs.sv */
// Purpose: Snooped link configuration and training registers with EQ offset.
// Assumes: Snoop and local write strobes are synchronous to i_clk, one cycle each.
// Notes:   Snooped DDC reads and writes and local writes share one update path for the clock ratio, sink config and source test registers.
// Functional notes
// RL1 - In full adaptive mode, positive polarity adds the offset to the adapted setting.
// RL2 - Negative polarity makes codes 0 to 7 subtract 8 down to 1.
// RL3 - Offset applies only in full adaptive mode, ignored otherwise.
// RL4 - Clock ratio bit 1 holds last value; 0 is one tenth, 1 one fortieth.
// RL5 - Bits 7-4 keep maximum transmit FFE level; code n allows levels 0 to n.
// RL6 - Rate field: 0 off, 1-2 three lanes, 3-6 four lanes.
// RL7 - Clock ratio, sink config and source test fields take the latest DDC read, DDC write or local write.
// RL8 - Source test bit 5 records the training timeout inhibit request.
// RL9 - Source test bits 3, 2, 1 select no FFE, de-emphasis only, pre-shoot only.
// RL10 - Lane 0/1 requests in first register nibbles, lanes 2/3 in second.
// RL11 - Request nibbles capture last DDC read value or local write.
// RL12 - Request code Eh advances that lane's FFE level, saturating at maximum.
// RL13 - Request code Fh on any lane clears all lanes' Max_tx_ffe_level to zero.
// RL14 - Control bit 3 selects offset polarity: 0 positive, 1 negative.
// RL15 - Reported optimal equalizer result already includes the offset.
// RL16 - Pattern policies 0 and 1 hold adaptation after a rate change until a snooped lane request read.
// RL17 - Offset-adjusted setting is clamped to 0 to 15.
`default_nettype none
module ltsr_regs
(
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  input  wire ltsr_pkg::ltsr_access_t i_local,
  input  wire ltsr_pkg::ltsr_access_t i_snoop,
  input  wire ltsr_pkg::ltsr_eq_mode_t i_eq_mode,
  input  wire logic [1:0]             i_pattern_policy,
  input  wire logic [3:0]             i_adapted_eq,
  output logic [7:0]                  o_rdata,
  output logic [3:0]                  o_eq_setting,
  output logic [15:0]                 o_lane_ffe_level,
  output logic                        o_bit_clock_period_ratio,
  output logic [3:0]                  o_link_rate_lane_select,
  output logic [2:0]                  o_active_lanes,
  output logic                        o_link_rate_enabled,
  output ltsr_pkg::ltsr_test_t        o_test,
  output logic                        o_adapt_allowed
);
  logic [7:0]  clock_ratio_q,  clock_ratio_d;
  logic [7:0]  sink_config_q,  sink_config_d;
  logic [7:0]  source_test_q,  source_test_d;
  logic [7:0]  lane01_req_q,   lane01_req_d;
  logic [7:0]  lane23_req_q,   lane23_req_d;
  logic [7:0]  eq_control2_q,  eq_control2_d;
  logic [15:0] ffe_level_q,    ffe_level_d;
  logic        rate_pending_q, rate_pending_d;
  logic [3:0]  eq_setting_q,   eq_setting_d;
  logic [15:0] req_nibbles;
  logic        snoop_any;
  logic        any_clear;
  logic        cfg_wr;
  logic [7:0]  cfg_addr;
  logic [7:0]  cfg_data;
  logic        req_rd;
  logic [7:0]  req_addr;
  logic [7:0]  req_data;

  // Offset-adjusted EQ with clamping instead of wrap.
  function automatic logic [3:0] apply_offset(input logic [3:0] base, input logic [2:0] mag,
                                              input logic neg);
    logic [5:0] sum;
    sum = 6'h00;
    if (!neg)
    begin
      sum = {2'b00, base} + {3'b000, mag}; // [RL1]
      apply_offset = (sum > {2'b00, ltsr_pkg::EQ_MAX}) ? ltsr_pkg::EQ_MAX : sum[3:0]; // [RL17]
    end
    else
    begin
      sum = {2'b00, base} + {3'b000, mag}; // [RL2]
      apply_offset = (sum < 6'h08) ? 4'h0 : 4'(sum - 6'h08); // [RL17]
    end
  endfunction

  // A snooped transfer takes priority over a local write in the same cycle; both are rare.
  always_comb
  begin
    snoop_any = i_snoop.wr | i_snoop.rd;
    cfg_wr   = snoop_any | i_local.wr;
    cfg_addr = snoop_any ? i_snoop.addr : i_local.addr;
    cfg_data = snoop_any ? i_snoop.data : i_local.data;
    req_rd   = i_snoop.rd | i_local.wr;
    req_addr = i_snoop.rd ? i_snoop.addr : i_local.addr;
    req_data = i_snoop.rd ? i_snoop.data : i_local.data;
  end

  always_comb
  begin
    clock_ratio_d  = clock_ratio_q;
    sink_config_d  = sink_config_q;
    source_test_d  = source_test_q;
    lane01_req_d   = lane01_req_q;
    lane23_req_d   = lane23_req_q;
    eq_control2_d  = eq_control2_q;
    ffe_level_d    = ffe_level_q;
    rate_pending_d = rate_pending_q;
    req_nibbles    = 16'h0000;
    any_clear      = 1'b0;
    if (cfg_wr && (cfg_addr == ltsr_pkg::OFS_CLOCK_RATIO))
      clock_ratio_d = cfg_data & ltsr_pkg::MASK_CLOCK_RATIO; // [RL4] [RL7]
    if (cfg_wr)
    begin
      unique case (cfg_addr)
        ltsr_pkg::OFS_SINK_CONFIG:
        begin
          sink_config_d = cfg_data; // [RL5] [RL7]
          if (cfg_data[3:0] != sink_config_q[3:0])
            rate_pending_d = 1'b1; // [RL16]
        end
        ltsr_pkg::OFS_SOURCE_TEST:
          source_test_d = cfg_data & ltsr_pkg::MASK_SOURCE_TEST; // [RL8] [RL9] [RL7]
        default:
        begin
        end
      endcase
    end
    if (i_local.wr && i_local.addr == ltsr_pkg::OFS_EQ_CONTROL2)
      eq_control2_d = i_local.data & ltsr_pkg::MASK_EQ_CONTROL2;
    if (req_rd && req_addr == ltsr_pkg::OFS_LANE01_REQ)
    begin
      lane01_req_d      = req_data; // [RL10] [RL11]
      req_nibbles[7:0]  = req_data;
      // A local write is not a read, so only a snooped read releases adaptation.
      if (i_snoop.rd)
        rate_pending_d  = 1'b0; // [RL16]
    end
    if (req_rd && req_addr == ltsr_pkg::OFS_LANE23_REQ)
    begin
      lane23_req_d      = req_data; // [RL10] [RL11]
      req_nibbles[15:8] = req_data;
      if (i_snoop.rd)
        rate_pending_d  = 1'b0; // [RL16]
    end
    for (int ln = 0; ln < 4; ln++)
      if (req_rd && req_nibbles[ln*4 +: 4] == ltsr_pkg::REQ_FFE_CLEAR)
        any_clear = 1'b1;
    for (int ln = 0; ln < 4; ln++)
    begin
      if (any_clear)
        ffe_level_d[ln*4 +: 4] = 4'h0; // [RL13]
      else if (req_rd && req_nibbles[ln*4 +: 4] == ltsr_pkg::REQ_FFE_ADVANCE
               && ffe_level_q[ln*4 +: 4] < sink_config_q[7:4])
        ffe_level_d[ln*4 +: 4] = ffe_level_q[ln*4 +: 4] + 4'h1; // [RL12]
    end
    if (i_eq_mode == ltsr_pkg::LTSR_EQM_FULL)
      eq_setting_d = apply_offset(i_adapted_eq, eq_control2_q[2:0],
                                  eq_control2_q[ltsr_pkg::POS_POLARITY]); // [RL1] [RL14] [RL15]
    else
      eq_setting_d = i_adapted_eq; // [RL3]
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      clock_ratio_q  <= ltsr_pkg::RST_BYTE;
      sink_config_q  <= ltsr_pkg::RST_BYTE;
      source_test_q  <= ltsr_pkg::RST_BYTE;
      lane01_req_q   <= ltsr_pkg::RST_BYTE;
      lane23_req_q   <= ltsr_pkg::RST_BYTE;
      eq_control2_q  <= ltsr_pkg::RST_BYTE;
      ffe_level_q    <= 16'h0000;
      rate_pending_q <= 1'b0;
      eq_setting_q   <= 4'h0;
    end
    else
    begin
      clock_ratio_q  <= clock_ratio_d;
      sink_config_q  <= sink_config_d;
      source_test_q  <= source_test_d;
      lane01_req_q   <= lane01_req_d;
      lane23_req_q   <= lane23_req_d;
      eq_control2_q  <= eq_control2_d;
      ffe_level_q    <= ffe_level_d;
      rate_pending_q <= rate_pending_d;
      eq_setting_q   <= eq_setting_d;
    end
  end

  always_comb
  begin
    unique case (i_local.addr)
      ltsr_pkg::OFS_CLOCK_RATIO: o_rdata = clock_ratio_q;
      ltsr_pkg::OFS_SINK_CONFIG: o_rdata = sink_config_q;
      ltsr_pkg::OFS_SOURCE_TEST: o_rdata = source_test_q;
      ltsr_pkg::OFS_LANE01_REQ:  o_rdata = lane01_req_q;
      ltsr_pkg::OFS_LANE23_REQ:  o_rdata = lane23_req_q;
      ltsr_pkg::OFS_EQ_CONTROL2: o_rdata = eq_control2_q;
      default:                   o_rdata = 8'h00;
    endcase
  end

  // Rate field decode; codes above six are unassigned and treated as disabled.
  always_comb
  begin
    o_link_rate_enabled = (sink_config_q[3:0] != 4'h0)
                          && (sink_config_q[3:0] <= ltsr_pkg::RATE_MAX_CODE); // [RL6]
    if (!o_link_rate_enabled)
      o_active_lanes = 3'h0;
    else if (sink_config_q[3:0] <= ltsr_pkg::RATE_THREE_LANE)
      o_active_lanes = 3'h3; // [RL6]
    else
      o_active_lanes = 3'h4; // [RL6]
  end

  assign o_eq_setting             = eq_setting_q;
  assign o_lane_ffe_level         = ffe_level_q;
  assign o_bit_clock_period_ratio = clock_ratio_q[ltsr_pkg::POS_RATIO];
  assign o_link_rate_lane_select  = sink_config_q[3:0];
  assign o_test = '{ffe_disable:     source_test_q[ltsr_pkg::POS_FFE_DISABLE],
                    deemph_only:     source_test_q[ltsr_pkg::POS_DEEMPH_ONLY],
                    test_a:          source_test_q[ltsr_pkg::POS_TEST_A],
                    timeout_inhibit: source_test_q[ltsr_pkg::POS_TIMEOUT_INH]};
  assign o_adapt_allowed          = !(rate_pending_q && !i_pattern_policy[1]); // [RL16]

  sequence s_clear_req;
    i_snoop.rd && i_snoop.addr == ltsr_pkg::OFS_LANE01_REQ
      && i_snoop.data[3:0] == ltsr_pkg::REQ_FFE_CLEAR;
  endsequence

  a_ffe_clear_all: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL13]
    s_clear_req |=> ffe_level_q == 16'h0000)
    else $error("Max_tx_ffe_level not cleared.");

  a_ffe_saturate: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL12]
    ffe_level_q[3:0] == sink_config_q[7:4] && $stable(sink_config_q) |=>
      ffe_level_q[3:0] <= $past(sink_config_q[7:4]) || ffe_level_q[3:0] == 4'h0)
    else $error("Lane 0 FFE level passed maximum.");

  a_eq_ignore_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL3]
    i_eq_mode != ltsr_pkg::LTSR_EQM_FULL |=> o_eq_setting == $past(i_adapted_eq))
    else $error("Offset applied outside full mode.");

  a_eq_positive: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL1]
    i_eq_mode == ltsr_pkg::LTSR_EQM_FULL && !eq_control2_q[3]
      && ({1'b0, i_adapted_eq} + {2'b00, eq_control2_q[2:0]} <= 5'h0F)
      |=> o_eq_setting == $past(i_adapted_eq) + $past({1'b0, eq_control2_q[2:0]}))
    else $error("Positive offset wrong.");

  a_eq_negative: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL2]
    i_eq_mode == ltsr_pkg::LTSR_EQM_FULL && eq_control2_q[3] && i_adapted_eq == 4'hF
      |=> o_eq_setting == 4'h7 + $past({1'b0, eq_control2_q[2:0]}))
    else $error("Negative offset wrong.");

  a_eq_clamp: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL17]
    i_eq_mode == ltsr_pkg::LTSR_EQM_FULL && eq_control2_q[3] && i_adapted_eq == 4'h0
      |=> o_eq_setting == 4'h0)
    else $error("Offset result wrapped.");

  a_ratio_snoop: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL4]
    i_snoop.wr && i_snoop.addr == ltsr_pkg::OFS_CLOCK_RATIO
      |=> o_bit_clock_period_ratio == $past(i_snoop.data[1]))
    else $error("Clock ratio not captured.");

  a_req_capture: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL11]
    i_snoop.rd && i_snoop.addr == ltsr_pkg::OFS_LANE23_REQ
      |=> lane23_req_q == $past(i_snoop.data))
    else $error("Pattern request not captured.");

  a_lane_decode: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL6]
    sink_config_q[3:0] == 4'h3 |-> o_active_lanes == 3'h4 && o_link_rate_enabled)
    else $error("Lane count decode wrong.");
endmodule // ltsr_regs
`default_nettype wire

/* tb/ltsr_src_model.sv */
// Purpose: Source controller model that issues snooped DDC transfers.
// Assumes: One transfer per call; the strobe lasts one clock.
// Notes:   The idle bus shows the inverted last address and data byte so stale data never looks valid.
`default_nettype none
module ltsr_src_model
(
  input  wire logic                  i_clk,
  output var ltsr_pkg::ltsr_access_t o_snoop
);
  timeunit 1ns;
  timeprecision 1ns;

  initial o_snoop = '0;

  task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_snoop <= '{wr: ~rd, rd: rd, addr: a, data: d};
    @(posedge i_clk);
    o_snoop <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    #1;
  endtask
endmodule // ltsr_src_model
`default_nettype wire

/* tb/test_link_training_snoop_regs.sv */
// Purpose: Self-checking bench for the snooped link training registers.
// Assumes: Local writes last one clock; reads are combinational on the address.
// Notes:   Drivers return 1 ns past their last edge so checks see settled registers.
`default_nettype none
module test_link_training_snoop_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  ltsr_pkg::ltsr_access_t  loc = '0;
  ltsr_pkg::ltsr_access_t  snp;
  ltsr_pkg::ltsr_eq_mode_t mode = ltsr_pkg::LTSR_EQM_FULL;
  logic [1:0]              policy = 2'h0;
  logic [3:0]              adapted = 4'h0;
  logic [7:0]              rdata;
  logic [3:0]              eq_set;
  logic [3:0]              rate;
  logic [15:0]             ffe;
  logic [2:0]              lanes;
  logic                    ratio;
  logic                    rate_en;
  logic                    allowed;
  ltsr_pkg::ltsr_test_t    tst;
  int                      err_total = 0;
  int                      n_tests = 0;

  always #25 clk = ~clk;

  ltsr_src_model u_src (.i_clk(clk), .o_snoop(snp));

  ltsr_regs u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_local(loc), .i_snoop(snp),
    .i_eq_mode(mode), .i_pattern_policy(policy), .i_adapted_eq(adapted),
    .o_rdata(rdata), .o_eq_setting(eq_set), .o_lane_ffe_level(ffe),
    .o_bit_clock_period_ratio(ratio), .o_link_rate_lane_select(rate),
    .o_active_lanes(lanes), .o_link_rate_enabled(rate_en), .o_test(tst),
    .o_adapt_allowed(allowed));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic lw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    loc <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(posedge clk);
    loc.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    loc.addr <= a;
    #1;
  endtask

  task automatic t_reset;
    logic [7:0] ofs [6] = '{8'h20, 8'h31, 8'h35, 8'h41, 8'h42, 8'h1E};
    foreach (ofs[i])
    begin
      rd(ofs[i]);
      chk(rdata, 8'h00);
    end
    chk(ffe, 16'h0000);
    chk(allowed, 1'b1);
  endtask

  task automatic t_ratio;
    lw(ltsr_pkg::OFS_CLOCK_RATIO, 8'hFF);
    chk(rdata, 8'h02);
    chk(ratio, 1'b1);
    u_src.xfer(1'b1, ltsr_pkg::OFS_CLOCK_RATIO, 8'h00);
    chk(ratio, 1'b0);
    u_src.xfer(1'b0, ltsr_pkg::OFS_CLOCK_RATIO, 8'h02);
    chk(ratio, 1'b1);
    lw(8'h77, 8'hFF);
    chk(rdata, 8'h00);
  endtask

  task automatic t_rate;
    for (int c = 0; c < 8; c++)
    begin
      u_src.xfer(1'b0, ltsr_pkg::OFS_SINK_CONFIG, {4'h3, c[3:0]});
      chk(rate, c[3:0]);
      chk(rate_en, c inside {[1:6]});
      if (c inside {[1:6]})
        chk(lanes, (c < 3) ? 3'h3 : 3'h4);
    end
  endtask

  task automatic t_test;
    logic [7:0] byt [4] = '{8'h20, 8'h08, 8'h04, 8'h02};
    logic [3:0] fld [4] = '{4'h1, 4'h8, 4'h4, 4'h2};
    lw(ltsr_pkg::OFS_SOURCE_TEST, 8'hFF);
    chk(rdata, 8'h2E);
    foreach (byt[i])
    begin
      u_src.xfer(1'b0, ltsr_pkg::OFS_SOURCE_TEST, byt[i]);
      chk(tst, fld[i]);
    end
  endtask

  task automatic t_ffe;
    logic [15:0] exp [3] = '{16'h0011, 16'h0022, 16'h0022};
    lw(ltsr_pkg::OFS_SINK_CONFIG, 8'h26);
    chk(rdata, 8'h26);
    foreach (exp[i])
    begin
      u_src.xfer(1'b1, ltsr_pkg::OFS_LANE01_REQ, 8'hEE);
      chk(ffe, exp[i]);
    end
    lw(ltsr_pkg::OFS_LANE23_REQ, 8'hE0);
    chk(ffe, 16'h1022);
    chk(rdata, 8'hE0);
    // A snooped write is not a request, so levels must not move.
    u_src.xfer(1'b0, ltsr_pkg::OFS_LANE01_REQ, 8'hEE);
    chk(ffe, 16'h1022);
    u_src.xfer(1'b1, ltsr_pkg::OFS_LANE01_REQ, 8'h0F);
    chk(ffe, 16'h0000);
    rd(ltsr_pkg::OFS_LANE01_REQ);
    chk(rdata, 8'h0F);
  endtask

  task automatic t_eq;
    logic [19:0] cs [10] = '{20'h0516B, 20'h051CF, 20'h0D163, 20'h0D110, 20'h0D1FC,
                             20'h0F198, 20'h08191, 20'h05066, 20'h05266, 20'h05366};
    lw(ltsr_pkg::OFS_EQ_CONTROL2, 8'hFF);
    chk(rdata, 8'hCF);
    foreach (cs[i])
    begin
      lw(ltsr_pkg::OFS_EQ_CONTROL2, cs[i][19:12]);
      @(posedge clk);
      mode <= ltsr_pkg::ltsr_eq_mode_t'(cs[i][9:8]);
      adapted <= cs[i][7:4];
      repeat (2) @(posedge clk);
      #1;
      chk(eq_set, cs[i][3:0]);
    end
  endtask

  task automatic t_policy;
    @(posedge clk);
    policy <= 2'h0;
    u_src.xfer(1'b0, ltsr_pkg::OFS_SINK_CONFIG, 8'h21);
    chk(allowed, 1'b0);
    u_src.xfer(1'b1, ltsr_pkg::OFS_LANE23_REQ, 8'h00);
    chk(allowed, 1'b1);
    @(posedge clk);
    policy <= 2'h2;
    u_src.xfer(1'b0, ltsr_pkg::OFS_SINK_CONFIG, 8'h23);
    chk(allowed, 1'b1);
    @(posedge clk);
    policy <= 2'h1;
    #1;
    chk(allowed, 1'b0);
    // A local write of a request register is not a read and must not release adaptation.
    lw(ltsr_pkg::OFS_LANE01_REQ, 8'h00);
    chk(allowed, 1'b0);
    u_src.xfer(1'b1, ltsr_pkg::OFS_LANE01_REQ, 8'h00);
    chk(allowed, 1'b1);
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // The whole sequence needs about 140 clocks; this bound is ample.
  initial
  begin
    repeat (3000) @(posedge clk);
    err_total++;
    finish_test();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_ratio();
    t_rate();
    t_test();
    t_ffe();
    t_eq();
    t_policy();
    finish_test();
  end
endmodule // test_link_training_snoop_regs
`default_nettype wire
